// [design/spp_regs.svh]
// Purpose: constants of the serial peripheral port
// Assumes: 10 MHz cpu clock
// Notes: half periods are in cpu clock cycles
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH
`define SPP_CTRL_RST 8'h00
`define SPP_STAT_RST 6'h00
// master sck half periods: cpu/4, /8, /16, /32, /64, /254
`define SPP_HALF_R0 7'h02
`define SPP_HALF_R1 7'h04
`define SPP_HALF_R2 7'h08
`define SPP_HALF_R3 7'h10
`define SPP_HALF_R4 7'h20
`define SPP_HALF_R5 7'h7F
`define SPP_LAST_EDGE 4'hF
`endif

// [design/spp_pkg.sv]
// Purpose: types of the serial peripheral port
// Assumes: nothing
// Notes: field order is msb first
`default_nettype none
package spp_pkg;
    typedef struct packed {
        logic irq_en;
        logic pe;
        logic ms;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic [2:0] rate;
    } spp_ctrl_type;
    typedef struct packed {
        logic done;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic soft_select_manage;
        logic ssl;
    } spp_stat_type;
    typedef enum logic {spp_idle, spp_shift} spp_state_type;
endpackage
`default_nettype wire

// [design/spp_core.sv]
// Purpose: serial peripheral port, master or slave, msb first
// Assumes: pins are asynchronous and pass two flip-flops
// Notes: register accesses arrive as one-cycle strobes
// Summary of operation
// RULE_01: six master rates, fastest cpu clock/4
// RULE_02: external master sck at most cpu/2
// RULE_03: master drives sck per rate, polarity, phase
// RULE_04: three-bit field picks master rate
// RULE_05: master and enable kept only with select high
// RULE_06: soft select level replaces pin when managed
// RULE_07: master data write loads, shifts out msb
// RULE_08: slave shifts loaded byte when clock arrives
// RULE_09: byte end sets done, interrupt if enabled
// RULE_10: master done clear: status access, data read
// RULE_11: slave done clear: status access, data access
// RULE_12: data writes ignored until status access
// RULE_13: master holds select per phase setting; the port drives no select pin
// RULE_14: select low as master: fault, drop enables
// RULE_15: fault clear: status read, control write
// RULE_16: fault blocks setting enable and master bits
// RULE_17: slave never raises mode fault
// RULE_18: byte end with done set flags overrun
// RULE_19: overrun keeps first byte, drops later
// RULE_20: status read clears overrun
// RULE_21: data write mid transfer discarded, collision
// RULE_22: collision flag raises no interrupt
// RULE_23: collision clear: status read, data read
// RULE_24: phase picks sample edge, idle equals polarity
`default_nettype none
`include "spp_regs.svh"
module spp_core (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // register strobes
    input wire logic ctrl_wr_i,
    input wire spp_pkg::spp_ctrl_type ctrl_wdata_i,
    input wire logic csr_rd_i,
    input wire logic csr_wr_i,
    input wire spp_pkg::spp_stat_type csr_wdata_i,
    input wire logic dr_rd_i,
    input wire logic dr_wr_i,
    input wire logic [7:0] dr_wdata_i,
    input wire logic cpu_irq_mask_i,
    // register views
    output logic [7:0] dr_rdata_o,
    output spp_pkg::spp_ctrl_type ctrl_o,
    output spp_pkg::spp_stat_type status_o,
    output logic irq_o,
    // pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i
);
    spp_pkg::spp_ctrl_type ctrl_reg, ctrl_next;
    spp_pkg::spp_stat_type stat_reg, stat_next;
    spp_pkg::spp_state_type state_reg, state_next;
    logic done_arm_reg, done_arm_next, write_collision_flag_arm_reg, write_collision_flag_arm_next;
    logic mode_fault_flag_arm_reg, mode_fault_flag_arm_next;
    logic [7:0] sr_reg, sr_next, rx_reg, rx_next, rxbuf_reg, rxbuf_next;
    logic [3:0] edge_reg, edge_next;
    logic [6:0] div_reg, div_next;
    logic sck_reg, sck_next;
    logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2;
    logic ss_s1, ss_s2;
    logic ss_eff, slave_act, run_ok, tick, edge_ev, byte_done, din;
    logic msamp_reg, msamp_next, mfin_reg, mfin_next;
    logic busy, blocked, load, sample;

    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    // RULE_04: code picks rate; six and seven run slowest
    function automatic logic [6:0] half_of(input logic [2:0] code);
        case (code)
            3'h0: half_of = `SPP_HALF_R0;
            3'h1: half_of = `SPP_HALF_R1;
            3'h2: half_of = `SPP_HALF_R2;
            3'h3: half_of = `SPP_HALF_R3;
            3'h4: half_of = `SPP_HALF_R4;
            default: half_of = `SPP_HALF_R5;
        endcase
    endfunction

    // ---------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2, ss_s1, ss_s2} <= 9'h003;
        end
        else
        begin
            {sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2, ss_s1, ss_s2} <=
                {sck_i, sck_s1, sck_s2, mosi_i, mosi_s1, miso_i, miso_s1, ss_n_i, ss_s1};
        end
    end

    // ---------------------------------------------------------
    // shared terms
    // ---------------------------------------------------------
    // RULE_06: soft select replaces pin
    assign ss_eff = stat_reg.soft_select_manage ? stat_reg.ssl : ss_s2;
    // RULE_02: slave edges are seen after sync, so cpu/2 at most
    assign slave_act = ctrl_reg.pe && !ctrl_reg.ms && !ss_eff;
    assign run_ok = ctrl_reg.ms ? ctrl_reg.pe : slave_act;
    assign busy = (state_reg == spp_pkg::spp_shift);
    // RULE_12: writes wait for the status access
    assign blocked = stat_reg.done && !done_arm_reg;
    assign load = dr_wr_i && !blocked && !busy;
    // RULE_01: divider from the cpu clock
    assign tick = busy && (div_reg == half_of(ctrl_reg.rate) - 7'h01);
    assign edge_ev = ctrl_reg.ms ? (tick && run_ok)
        : (slave_act && (sck_s2 != sck_s3));
    assign byte_done = edge_ev && (edge_reg == `SPP_LAST_EDGE);
    assign din = ctrl_reg.ms ? miso_s2 : mosi_s2;
    // RULE_24: even edges lead, phase picks the sample edge
    assign sample = (edge_reg[0] == ctrl_reg.clock_phase_bit);

    // ---------------------------------------------------------
    // shifter
    // ---------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        {sr_next, rx_next, rxbuf_next} = {sr_reg, rx_reg, rxbuf_reg};
        {edge_next, div_next, sck_next} = {edge_reg, div_reg, sck_reg};
        {msamp_next, mfin_next} = 2'h0;
        // RULE_07: master load starts the transfer
        // RULE_08: slave load waits for the master clock
        if (load)
        begin
            sr_next = dr_wdata_i;
            if (ctrl_reg.ms && ctrl_reg.pe)
            begin
                state_next = spp_pkg::spp_shift;
                {edge_next, div_next} = 11'h000;
            end
        end
        if (busy)
            div_next = tick ? 7'h00 : div_reg + 7'h01;
        // master takes miso a cycle late: two pin flops lag cpu/4
        if (msamp_reg)
            rx_next = {rx_reg[6:0], din};
        if (mfin_reg)
            rxbuf_next = msamp_reg ? {rx_reg[6:0], din} : rx_reg;
        if (edge_ev)
        begin
            state_next = spp_pkg::spp_shift;
            edge_next = edge_reg + 4'h1;
            // RULE_03: master sck toggles each half period
            if (ctrl_reg.ms)
                sck_next = !sck_reg;
            msamp_next = ctrl_reg.ms && sample;
            if (sample && !ctrl_reg.ms)
                rx_next = {rx_reg[6:0], din};
            // msb already sits on the line before the first edge
            if (!sample && edge_reg != 4'h0)
                sr_next = {sr_reg[6:0], 1'b0};
            if (byte_done)
            begin
                state_next = spp_pkg::spp_idle;
                edge_next = 4'h0;
                mfin_next = ctrl_reg.ms && !stat_reg.done;
                // RULE_19: overrun keeps the first byte
                if (!stat_reg.done && !ctrl_reg.ms)
                    rxbuf_next = sample ? {rx_reg[6:0], din} : rx_reg;
            end
        end
        // select released or fault mid byte aborts the byte
        if (busy && !run_ok)
        begin
            state_next = spp_pkg::spp_idle;
            edge_next = 4'h0;
        end
        // RULE_24: idle level follows polarity
        if (state_next == spp_pkg::spp_idle)
            sck_next = ctrl_next.clock_polarity_bit;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= spp_pkg::spp_idle;
            {sr_reg, rx_reg, rxbuf_reg} <= 24'h000000;
            {edge_reg, div_reg, sck_reg, msamp_reg, mfin_reg} <= 14'h0000;
        end
        else
        begin
            state_reg <= state_next;
            {sr_reg, rx_reg, rxbuf_reg} <= {sr_next, rx_next, rxbuf_next};
            {edge_reg, div_reg, sck_reg, msamp_reg, mfin_reg} <=
                {edge_next, div_next, sck_next, msamp_next, mfin_next};
        end
    end

    // ---------------------------------------------------------
    // control and flags
    // ---------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        stat_next = stat_reg;
        {done_arm_next, write_collision_flag_arm_next, mode_fault_flag_arm_next} =
            {done_arm_reg, write_collision_flag_arm_reg, mode_fault_flag_arm_reg};
        if (csr_wr_i)
            {stat_next.soft_select_manage, stat_next.ssl} = {csr_wdata_i.soft_select_manage, csr_wdata_i.ssl};
        if (ctrl_wr_i)
        begin
            ctrl_next = ctrl_wdata_i;
            // RULE_15: control write ends the fault sequence
            if (mode_fault_flag_arm_reg)
                {stat_next.mode_fault_flag, mode_fault_flag_arm_next} = 2'h0;
            // RULE_16: no re-enable while the fault stands
            else if (stat_reg.mode_fault_flag)
                {ctrl_next.pe, ctrl_next.ms} = {ctrl_reg.pe, ctrl_reg.ms};
        end
        if ((csr_rd_i || csr_wr_i) && stat_reg.done)
            done_arm_next = 1'b1;
        if (csr_rd_i && stat_reg.write_collision_flag)
            write_collision_flag_arm_next = 1'b1;
        if (csr_rd_i && stat_reg.mode_fault_flag)
            mode_fault_flag_arm_next = 1'b1;
        // RULE_20: status read clears overrun
        if (csr_rd_i)
            stat_next.overrun_flag = 1'b0;
        // RULE_10: master clears on data read
        // RULE_11: slave clears on data read or write
        if (done_arm_reg && (dr_rd_i || (dr_wr_i && !ctrl_reg.ms)))
            {stat_next.done, done_arm_next} = 2'h0;
        // RULE_23: data read after status read
        if (write_collision_flag_arm_reg && dr_rd_i)
            {stat_next.write_collision_flag, write_collision_flag_arm_next} = 2'h0;
        // sets come last so they win over clears
        // RULE_21: collision while shifting
        if (dr_wr_i && busy)
            stat_next.write_collision_flag = 1'b1;
        // RULE_18: byte end while done still set
        if (byte_done && stat_reg.done)
            stat_next.overrun_flag = 1'b1;
        // RULE_09: byte end sets done
        if (byte_done)
            stat_next.done = 1'b1;
        // RULE_05: master bits drop without select high
        // RULE_14: fault forces slave and disables
        // RULE_17: only a master can fault
        if (ctrl_reg.ms && !ss_eff)
            {stat_next.mode_fault_flag, mode_fault_flag_arm_next, ctrl_next.pe, ctrl_next.ms} = 4'h8;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg <= `SPP_CTRL_RST;
            stat_reg <= `SPP_STAT_RST;
            {done_arm_reg, write_collision_flag_arm_reg, mode_fault_flag_arm_reg} <= 3'h0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            {done_arm_reg, write_collision_flag_arm_reg, mode_fault_flag_arm_reg} <= {done_arm_next, write_collision_flag_arm_next, mode_fault_flag_arm_next};
        end
    end

    // ---------------------------------------------------------
    // outputs
    // ---------------------------------------------------------
    assign dr_rdata_o = rxbuf_reg;
    assign ctrl_o = ctrl_reg;
    assign status_o = stat_reg;
    // RULE_22: collision stays out of the request
    assign irq_o = ctrl_reg.irq_en && !cpu_irq_mask_i
        && (stat_reg.done || stat_reg.mode_fault_flag || stat_reg.overrun_flag);
    assign sck_o = sck_reg;
    assign sck_oe_o = ctrl_reg.ms && ctrl_reg.pe;
    assign mosi_o = sr_reg[7];
    assign mosi_oe_o = ctrl_reg.ms && ctrl_reg.pe;
    assign miso_o = sr_reg[7];
    assign miso_oe_o = slave_act;

    // ---------------------------------------------------------
    // assertions
    // ---------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_done_armed;
        stat_reg.done && csr_rd_i && ctrl_reg.ms ##1 dr_rd_i && !byte_done;
    endsequence
    property p_done_set;
        byte_done |=> stat_reg.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set"); // RULE_09
    property p_done_clear;
        s_done_armed |=> !stat_reg.done;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done kept"); // RULE_10
    property p_ovr;
        byte_done && stat_reg.done |=> stat_reg.overrun_flag && $stable(rxbuf_reg);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun wrong"); // RULE_18
    property p_blocked;
        dr_wr_i && blocked && !busy && ctrl_reg.ms |=> !busy;
    endproperty
    a_blocked: assert property (p_blocked) else $error("write not blocked"); // RULE_12
    property p_fault;
        ctrl_reg.ms && !ss_eff |=> stat_reg.mode_fault_flag && !ctrl_reg.pe && !ctrl_reg.ms;
    endproperty
    a_fault: assert property (p_fault) else $error("fault missed"); // RULE_14
    property p_slave_nofault;
        !ctrl_reg.ms |=> !$rose(stat_reg.mode_fault_flag);
    endproperty
    a_slave_nofault: assert property (p_slave_nofault) else $error("slave fault"); // RULE_17
    property p_write_collision_flag;
        dr_wr_i && busy |=> stat_reg.write_collision_flag && ($past(edge_ev) || $stable(sr_reg));
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed"); // RULE_21
    property p_load;
        load && ctrl_reg.ms && ctrl_reg.pe |=> busy && mosi_o == $past(dr_wdata_i[7]);
    endproperty
    a_load: assert property (p_load) else $error("master load wrong"); // RULE_07
    property p_fast;
        tick && ss_eff && !byte_done && ctrl_reg.ms && ctrl_reg.rate == 3'h0 |=> !tick ##1 tick;
    endproperty
    a_fast: assert property (p_fast) else $error("rate wrong"); // RULE_01
endmodule
`default_nettype wire

// [design/spp_unused_note.sv]
`default_nettype none
`default_nettype wire

// [verification/spp_peer_model.sv]
// Purpose: peer slave seen by the port in master mode
// Assumes: select is driven by the bench
// Notes: a released miso shows the inverse of its last level
`default_nettype none
module spp_peer_model (
    // serial pins
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic sel_n_i,
    output logic miso_o,
    // mode and data
    input wire logic clock_polarity_bit_i,
    input wire logic clock_phase_bit_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int shifts = 0;
    int k;
    initial miso_o = 1'b0;
    // ----------------------------------------
    // edge handling
    // ----------------------------------------
    // phase picks edge
    always @(sck_i)
    begin
        if (!sel_n_i && ((sck_i != clock_polarity_bit_i) != clock_phase_bit_i))
            rx_o = {rx_o[6:0], mosi_i};
        else if (!sel_n_i)
            shifts++;
    end
    always @(negedge sel_n_i)
        shifts = 0;
    // released line flips so stale data never matches by luck
    always @(sel_n_i or shifts or tx_i)
    begin
        k = shifts - int'(clock_phase_bit_i);
        if (sel_n_i)
            miso_o = ~miso_o;
        else
            miso_o = tx_i[7 - (k < 0 ? 0 : (k > 7 ? 7 : k))];
    end
endmodule
`default_nettype wire

// [verification/serial_peripheral_port_test.sv]
// Purpose: self-checking bench of the serial peripheral port
// Assumes: strobes take effect one cycle after their edge
// Notes: bench plays the external master in slave mode
`default_nettype none
module serial_peripheral_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] stb = 5'h00;
    logic [7:0] wd = 8'h00;
    logic irq_mask = 1'b0;
    logic bm_sck = 1'b0;
    logic bm_mosi = 1'b0;
    logic ss_n = 1'b1;
    logic pm_sel_n = 1'b1;
    logic [7:0] pm_tx = 8'h00;
    logic [7:0] pm_rx, dr_rdata;
    logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pm_miso;
    spp_pkg::spp_ctrl_type ctrl;
    spp_pkg::spp_stat_type stat;
    wire logic sck_w = sck_oe ? sck_o : bm_sck;
    wire logic mosi_w = mosi_oe ? mosi_o : bm_mosi;
    wire logic miso_w = miso_oe ? miso_o : pm_miso;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int half[6] = '{2, 4, 8, 16, 32, 127};
    logic [31:0] seed = 32'hDE0CE49D;
    logic [7:0] exp_q[$];

    spp_core spp_core_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .ctrl_wr_i(stb[0]),
        .ctrl_wdata_i(spp_pkg::spp_ctrl_type'(wd)), .csr_rd_i(stb[1]), .csr_wr_i(stb[2]),
        .csr_wdata_i(spp_pkg::spp_stat_type'(wd[5:0])), .dr_rd_i(stb[3]), .dr_wr_i(stb[4]),
        .dr_wdata_i(wd), .cpu_irq_mask_i(irq_mask), .dr_rdata_o(dr_rdata), .ctrl_o(ctrl),
        .status_o(stat), .irq_o(irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(ss_n));
    spp_peer_model spp_peer_model_i (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(pm_sel_n),
        .miso_o(pm_miso), .clock_polarity_bit_i(ctrl.clock_polarity_bit), .clock_phase_bit_i(ctrl.clock_phase_bit), .tx_i(pm_tx), .rx_o(pm_rx));

    // ----------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // 0 ctrl wr, 1 status rd, 2 status wr, 3 data rd, 4 data wr
    task automatic strobe(input int k, input logic [7:0] d);
        @(posedge mclk_i);
        wd <= d;
        stb[k] <= 1'b1;
        @(posedge mclk_i);
        stb[k] <= 1'b0;
        // one more edge so the effect is settled when read
        @(posedge mclk_i);
    endtask
    task automatic slave_byte(input logic [7:0] b, output logic [7:0] got);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge mclk_i);
            bm_mosi <= b[i];
            bm_sck <= 1'b1;
            tick(6);
            got = {got[6:0], miso_w};
            bm_sck <= 1'b0;
            tick(6);
        end
    endtask
    task report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int r;
        int m;
        logic [7:0] tx;
        logic [7:0] got;
        logic mo;
        spp_pkg::spp_ctrl_type c;
        tick(5);
        nrst_i <= 1'b1;
        chk(ctrl, 8'h00);
        chk(8'(stat), 8'h00);
        chk(8'({sck_oe, mosi_oe, miso_oe, irq}), 8'h00);
        // soft select high while the pin is low: no fault
        strobe(2, 8'h03);
        ss_n <= 1'b0;
        for (r = 0; r < 6; r++)
        begin
            c = spp_pkg::spp_ctrl_type'({3'b111, r[1:0], r[2:0]});
            strobe(0, c);
            tick(2);
            chk(8'(sck_o), 8'(c.clock_polarity_bit));
            tx = 8'(xs());
            got = 8'(xs());
            exp_q.push_back(got);
            pm_tx <= got;
            pm_sel_n <= 1'b0;
            strobe(4, tx);
            m = 0;
            while (sck_o === c.clock_polarity_bit && m < 300)
            begin
                @(posedge mclk_i);
                m++;
            end
            m = 0;
            while (sck_o !== c.clock_polarity_bit && m < 300)
            begin
                @(posedge mclk_i);
                m++;
            end
            chk(8'(m), 8'(half[r]));
            strobe(4, ~tx);
            chk(8'({stat.write_collision_flag, irq}), 8'h02);
            for (m = 0; m < 5000 && stat.done !== 1'b1; m++)
                @(posedge mclk_i);
            // received byte lands one cycle after done
            @(posedge mclk_i);
            chk(8'(irq), 8'h01);
            chk(pm_rx, tx);
            chk(dr_rdata, exp_q.pop_front());
            mo = mosi_o;
            strobe(4, {~mo, 7'h5A});
            tick(4);
            chk(8'(sck_o), 8'(c.clock_polarity_bit));
            chk(8'(mosi_o), 8'(mo));
            pm_sel_n <= 1'b1;
            strobe(1, 8'h00);
            strobe(3, 8'h00);
            chk(8'(stat), 8'h03);
        end
        ss_n <= 1'b1;
        strobe(2, 8'h00);
        strobe(0, 8'hE0);
        chk(ctrl, 8'hE0);
        ss_n <= 1'b0;
        tick(5);
        chk(8'(stat), 8'h04);
        chk(ctrl, 8'h80);
        chk(8'({sck_oe, mosi_oe, irq}), 8'h01);
        irq_mask <= 1'b1;
        @(posedge mclk_i);
        chk(8'(irq), 8'h00);
        irq_mask <= 1'b0;
        strobe(0, 8'hE0);
        chk(ctrl, 8'h80);
        ss_n <= 1'b1;
        tick(3);
        strobe(1, 8'h00);
        strobe(0, 8'h48);
        chk(8'(stat), 8'h00);
        chk(ctrl, 8'h48);
        // slave mode, phase 1
        strobe(4, 8'hC3);
        ss_n <= 1'b0;
        tick(3);
        tx = 8'(xs());
        slave_byte(tx, got);
        tick(4);
        chk(got, 8'hC3);
        chk(8'(stat), 8'h20);
        chk(dr_rdata, tx);
        slave_byte(8'(xs()), got);
        tick(4);
        chk(8'(stat), 8'h28);
        chk(dr_rdata, tx);
        strobe(1, 8'h00);
        chk(8'(stat), 8'h20);
        strobe(4, 8'h00);
        chk(8'(stat), 8'h00);
        ss_n <= 1'b1;
        report_and_stop();
    end
endmodule
`default_nettype wire
